// ==== rtl/cihc_map.vh ====
// Register indices, reset values and timing counts of the interrupt and
// halt controller. Assumes a 4-bit data path in the low bits of a word.
`ifndef CIHC_MAP_VH
`define CIHC_MAP_VH

// Register indices; byte address is four times the index
`define CIHC_IDX_KLO_SEL 8'h90
`define CIHC_IDX_KLO_CMP 8'h92
`define CIHC_IDX_KHI_SEL 8'h94
`define CIHC_IDX_KHI_CMP 8'h96
`define CIHC_IDX_M_PT 8'hF0
`define CIHC_IDX_M_SIF 8'hF1
`define CIHC_IDX_M_KHI 8'hF2
`define CIHC_IDX_M_KLO 8'hF3
`define CIHC_IDX_M_CT 8'hF4
`define CIHC_IDX_F_PT 8'hF8
`define CIHC_IDX_F_SIF 8'hF9
`define CIHC_IDX_F_KHI 8'hFA
`define CIHC_IDX_F_KLO 8'hFB
`define CIHC_IDX_F_CT 8'hFC

// Field positions in the serial registers
`define CIHC_SIF_RX 0
`define CIHC_SIF_TX 1
`define CIHC_SIF_ERR 2

// Reset values
`define CIHC_RST_SEL 4'h0
`define CIHC_RST_CMP 4'hF
`define CIHC_RST_MASK 4'h0
`define CIHC_RST_FLAG 4'h0

// Vector page and low nibbles, highest priority first
`define CIHC_VEC_PAGE 4'h1
`define CIHC_VEC_NONE 4'h0
`define CIHC_VEC_PT 4'h2
`define CIHC_VEC_SERR 4'h4
`define CIHC_VEC_SRX 4'h6
`define CIHC_VEC_STX 4'h8
`define CIHC_VEC_KHI 4'hA
`define CIHC_VEC_KLO 4'hC
`define CIHC_VEC_CT 4'hE

// Service length in system clocks
`define CIHC_SERV_CYC 4'd12

// Watchdog period while halted
`define CIHC_WDT_SEC 3
`define CIHC_CLK_HZ 100000000
`define CIHC_WDT_CYC (`CIHC_WDT_SEC * `CIHC_CLK_HZ)

`endif

// ==== rtl/cihc_irq_halt.v ====
// Interrupt factor flags, masks, priority vectoring and halt control.
// Assumes event inputs are one-cycle pulses or levels synchronous to clk_i.
//
// Contract
// - Request only when flag set, its mask 1, and interrupt enable 1.
// - Accepting an interrupt clears the interrupt enable flag.
// - Flags are read-only; reading a flag register clears its flags.
// - Reset clears all factor flags.
// - Timer zero sets F8 bit0; serial error/rx/tx set F9 bits 2/0/1.
// - Qualifying upper key edge sets FA bit0; lower group sets FB bit0.
// - Falling 1/2/8/16 Hz taps set FC bits 3/2/1/0.
// - Flags set even when masked; mask blocks only the request.
// - Mask bits read/write; 1 enables, 0 inhibits the request.
// - Reset clears all mask bits.
// - Lower key select bits at 90 enable each input; reset 0.
// - Lower key compare bits at 92 choose transition; reset 1.
// - Service starts only after the current instruction completes.
// - Push next PC to stack, then load page-1 vector 02 to 0E.
// - Push and vector load together take 12 system clocks.
// - Vectors 102 timer down to 10E clock timer, by priority.
// - Request supplies low four PC bits; rest selects page 1.
// - Vector lies in the bank the PC holds at interrupt time.
// - Halt stops execution while the oscillator keeps running.
// - An interrupt request wakes the halted CPU.
// - Without wake-up, watchdog forces restart from reset state.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "cihc_map.vh"

module cihc_irq_halt #(
  parameter PC_W = 13,
  parameter [31:0] WDT_CYC = `CIHC_WDT_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire ptm_zero_i,
  input wire sif_err_i,
  input wire sif_rx_i,
  input wire sif_tx_i,
  input wire [3:0] key_hi_i,
  input wire [3:0] key_lo_i,
  input wire [3:0] ct_tap_i,
  input wire irq_en_set_i,
  input wire irq_en_clr_i,
  input wire instr_end_i,
  input wire halt_exec_i,
  input wire [PC_W-1:0] pc_next_i,
  output wire irq_o,
  output wire ie_o,
  output wire halted_o,
  output wire serv_busy_o,
  output reg stack_push_o,
  output reg [PC_W-1:0] stack_pc_o,
  output reg pc_load_o,
  output reg [PC_W-1:0] pc_vector_o,
  output reg wdt_restart_o
);

  localparam S_IDLE = 1'b0;
  localparam S_SERV = 1'b1;

  // Key edge against compare level: fires when input leaves compare value
  function [3:0] key_hit;
    input [3:0] prev;
    input [3:0] cur;
    input [3:0] sel;
    input [3:0] cmp;
    begin
      key_hit = sel & ~(prev ^ cmp) & (cur ^ cmp);
    end
  endfunction

  // Fixed priority, returns low PC nibble of the winning vector
  function [3:0] prio_vec;
    input [6:0] p;
    begin
      if (p[0]) prio_vec = `CIHC_VEC_PT;
      else if (p[1]) prio_vec = `CIHC_VEC_SERR;
      else if (p[2]) prio_vec = `CIHC_VEC_SRX;
      else if (p[3]) prio_vec = `CIHC_VEC_STX;
      else if (p[4]) prio_vec = `CIHC_VEC_KHI;
      else if (p[5]) prio_vec = `CIHC_VEC_KLO;
      else if (p[6]) prio_vec = `CIHC_VEC_CT;
      else prio_vec = `CIHC_VEC_NONE;
    end
  endfunction

  reg [3:0] klo_sel_q, klo_cmp_q, khi_sel_q, khi_cmp_q;
  reg m_pt_q, m_khi_q, m_klo_q;
  reg [2:0] m_sif_q;
  reg [3:0] m_ct_q;
  reg f_pt_q, f_khi_q, f_klo_q;
  reg [2:0] f_sif_q;
  reg [3:0] f_ct_q;
  reg [3:0] key_hi_q, key_lo_q, ct_tap_q;
  reg ack_q;
  reg [3:0] rd_bits_q;
  reg ie_q;
  reg halted_q;
  reg state_q;
  reg [3:0] cnt_q;
  reg [3:0] vec_q;
  reg [PC_W-13:0] bank_q;
  reg [31:0] wdt_q;
  reg [3:0] rd_d;

  wire bus_req = avs_read_i | avs_write_i;
  wire bus_done = bus_req & ack_q;
  wire wr_en = avs_write_i & bus_done & avs_byteenable_i[0];
  wire rd_done = avs_read_i & bus_done;
  wire [3:0] wd = avs_writedata_i[3:0];

  // One wait state: data is registered before waitrequest drops
  assign avs_waitrequest_o = bus_req & ~ack_q;

  wire [3:0] kh_ev = key_hit(key_hi_q, key_hi_i, khi_sel_q, khi_cmp_q);
  wire [3:0] kl_ev = key_hit(key_lo_q, key_lo_i, klo_sel_q, klo_cmp_q);
  wire [3:0] ct_ev = ct_tap_q & ~ct_tap_i;

  wire [6:0] pend;
  assign pend[0] = f_pt_q & m_pt_q;
  assign pend[1] = f_sif_q[`CIHC_SIF_ERR] & m_sif_q[`CIHC_SIF_ERR];
  assign pend[2] = f_sif_q[`CIHC_SIF_RX] & m_sif_q[`CIHC_SIF_RX];
  assign pend[3] = f_sif_q[`CIHC_SIF_TX] & m_sif_q[`CIHC_SIF_TX];
  assign pend[4] = f_khi_q & m_khi_q;
  assign pend[5] = f_klo_q & m_klo_q;
  assign pend[6] = |(f_ct_q & m_ct_q);

  assign irq_o = (|pend) & ie_q;
  assign ie_o = ie_q;
  assign halted_o = halted_q;
  assign serv_busy_o = (state_q == S_SERV);

  // Halted CPU sits at a boundary already
  wire boundary = instr_end_i | halted_q;
  wire accept = irq_o & boundary & (state_q == S_IDLE);

  always @* begin
    rd_d = 4'h0;
    case (avs_address_i)
      `CIHC_IDX_KLO_SEL: rd_d = klo_sel_q;
      `CIHC_IDX_KLO_CMP: rd_d = klo_cmp_q;
      `CIHC_IDX_KHI_SEL: rd_d = khi_sel_q;
      `CIHC_IDX_KHI_CMP: rd_d = khi_cmp_q;
      `CIHC_IDX_M_PT: rd_d = {3'b000, m_pt_q};
      `CIHC_IDX_M_SIF: rd_d = {1'b0, m_sif_q};
      `CIHC_IDX_M_KHI: rd_d = {3'b000, m_khi_q};
      `CIHC_IDX_M_KLO: rd_d = {3'b000, m_klo_q};
      `CIHC_IDX_M_CT: rd_d = m_ct_q;
      `CIHC_IDX_F_PT: rd_d = {3'b000, f_pt_q};
      `CIHC_IDX_F_SIF: rd_d = {1'b0, f_sif_q};
      `CIHC_IDX_F_KHI: rd_d = {3'b000, f_khi_q};
      `CIHC_IDX_F_KLO: rd_d = {3'b000, f_klo_q};
      `CIHC_IDX_F_CT: rd_d = f_ct_q;
      default: rd_d = 4'h0;
    endcase
  end

  // Bus handshake and read capture
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      rd_bits_q <= 4'h0;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (avs_read_i & ~ack_q) begin
        avs_readdata_o <= {28'h0000000, rd_d};
        rd_bits_q <= rd_d;
      end
    end
  end

  // Only the bits actually returned are cleared, so a flag that rises
  // between capture and completion survives the read
  wire clr_pt = rd_done & (avs_address_i == `CIHC_IDX_F_PT);
  wire clr_sif = rd_done & (avs_address_i == `CIHC_IDX_F_SIF);
  wire clr_khi = rd_done & (avs_address_i == `CIHC_IDX_F_KHI);
  wire clr_klo = rd_done & (avs_address_i == `CIHC_IDX_F_KLO);
  wire clr_ct = rd_done & (avs_address_i == `CIHC_IDX_F_CT);
  wire [2:0] sif_ev;
  assign sif_ev[`CIHC_SIF_RX] = sif_rx_i;
  assign sif_ev[`CIHC_SIF_TX] = sif_tx_i;
  assign sif_ev[`CIHC_SIF_ERR] = sif_err_i;

  // Factor flags, set wins over clear, mask not involved
  always @(posedge clk_i) begin
    if (rst_i) begin
      f_pt_q <= 1'b0;
      f_sif_q <= 3'b000;
      f_khi_q <= 1'b0;
      f_klo_q <= 1'b0;
      f_ct_q <= `CIHC_RST_FLAG;
      key_hi_q <= 4'h0;
      key_lo_q <= 4'h0;
      ct_tap_q <= 4'h0;
    end else begin
      key_hi_q <= key_hi_i;
      key_lo_q <= key_lo_i;
      ct_tap_q <= ct_tap_i;
      f_pt_q <= (f_pt_q & ~(clr_pt & rd_bits_q[0])) | ptm_zero_i;
      f_sif_q <= (f_sif_q & ~({3{clr_sif}} & rd_bits_q[2:0]))
        | sif_ev;
      f_khi_q <= (f_khi_q & ~(clr_khi & rd_bits_q[0])) | (|kh_ev);
      f_klo_q <= (f_klo_q & ~(clr_klo & rd_bits_q[0])) | (|kl_ev);
      f_ct_q <= (f_ct_q & ~({4{clr_ct}} & rd_bits_q)) | ct_ev;
    end
  end

  // Writable registers; flag indices ignore writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      klo_sel_q <= `CIHC_RST_SEL;
      klo_cmp_q <= `CIHC_RST_CMP;
      khi_sel_q <= `CIHC_RST_SEL;
      khi_cmp_q <= `CIHC_RST_CMP;
      m_pt_q <= 1'b0;
      m_sif_q <= 3'b000;
      m_khi_q <= 1'b0;
      m_klo_q <= 1'b0;
      m_ct_q <= `CIHC_RST_MASK;
    end else if (wr_en) begin
      // Mask writes while enabled are accepted; keeping them safe is
      // left to software
      case (avs_address_i)
        `CIHC_IDX_KLO_SEL: klo_sel_q <= wd;
        `CIHC_IDX_KLO_CMP: klo_cmp_q <= wd;
        `CIHC_IDX_KHI_SEL: khi_sel_q <= wd;
        `CIHC_IDX_KHI_CMP: khi_cmp_q <= wd;
        `CIHC_IDX_M_PT: m_pt_q <= wd[0];
        `CIHC_IDX_M_SIF: m_sif_q <= wd[2:0];
        `CIHC_IDX_M_KHI: m_khi_q <= wd[0];
        `CIHC_IDX_M_KLO: m_klo_q <= wd[0];
        `CIHC_IDX_M_CT: m_ct_q <= wd;
        default: m_pt_q <= m_pt_q;
      endcase
    end
  end

  // Interrupt enable flag held for the CPU
  always @(posedge clk_i) begin
    if (rst_i) begin
      ie_q <= 1'b0;
    end else if (accept) begin
      ie_q <= 1'b0;
    end else if (irq_en_clr_i) begin
      ie_q <= 1'b0;
    end else if (irq_en_set_i) begin
      ie_q <= 1'b1;
    end
  end

  // Service sequence: push on entry, vector load on the twelfth clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      cnt_q <= 4'd0;
      vec_q <= `CIHC_VEC_NONE;
      bank_q <= {(PC_W-12){1'b0}};
      stack_push_o <= 1'b0;
      stack_pc_o <= {PC_W{1'b0}};
      pc_load_o <= 1'b0;
      pc_vector_o <= {PC_W{1'b0}};
    end else begin
      stack_push_o <= 1'b0;
      pc_load_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (accept) begin
            state_q <= S_SERV;
            cnt_q <= 4'd1;
            vec_q <= prio_vec(pend);
            bank_q <= pc_next_i[PC_W-1:12];
            stack_push_o <= 1'b1;
            stack_pc_o <= pc_next_i;
          end
        end
        S_SERV: begin
          if (cnt_q == `CIHC_SERV_CYC - 4'd1) begin
            state_q <= S_IDLE;
            cnt_q <= 4'd0;
            pc_load_o <= 1'b1;
            pc_vector_o <= {bank_q, `CIHC_VEC_PAGE, 4'h0, vec_q};
          end else begin
            cnt_q <= cnt_q + 4'd1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Halt; clock keeps running so flags and watchdog still advance
  always @(posedge clk_i) begin
    if (rst_i) begin
      halted_q <= 1'b0;
      wdt_q <= 32'h00000000;
      wdt_restart_o <= 1'b0;
    end else begin
      wdt_restart_o <= 1'b0;
      if (halted_q) begin
        if (irq_o) begin
          halted_q <= 1'b0;
          wdt_q <= 32'h00000000;
        end else if (wdt_q == WDT_CYC - 32'd1) begin
          halted_q <= 1'b0;
          wdt_q <= 32'h00000000;
          wdt_restart_o <= 1'b1;
        end else begin
          wdt_q <= wdt_q + 32'd1;
        end
      end else if (halt_exec_i) begin
        halted_q <= 1'b1;
        wdt_q <= 32'h00000000;
      end
    end
  end

endmodule

// ==== bench/cihc_checker.sv ====
// Checker for service, vectoring and halt of the interrupt controller.
// Sees only top ports; one clock domain, synchronous reset.
`timescale 1ns/1ps
module cihc_checker #(
  parameter PC_W = 13
) (
  input wire clk_i,
  input wire rst_i,
  input wire instr_end_i,
  input wire halt_exec_i,
  input wire [PC_W-1:0] pc_next_i,
  input wire irq_o,
  input wire ie_o,
  input wire halted_o,
  input wire serv_busy_o,
  input wire stack_push_o,
  input wire [PC_W-1:0] stack_pc_o,
  input wire pc_load_o,
  input wire [PC_W-1:0] pc_vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_irq_gate: assert property (irq_o |-> ie_o)
    else $error("request while disabled");
  chk_ie_clear: assert property (stack_push_o |-> !ie_o)
    else $error("enable left set after accept");
  chk_after_instr: assert property (stack_push_o |->
    $past(instr_end_i) || $past(halted_o))
    else $error("accept inside instruction");
  chk_serv_len: assert property (stack_push_o |=>
    !pc_load_o [*8] ##3 pc_load_o)
    else $error("service length wrong");
  chk_stack_pc: assert property (stack_push_o |->
    stack_pc_o == $past(pc_next_i))
    else $error("wrong pc pushed");
  chk_vec_page: assert property (pc_load_o |-> pc_vector_o[11:4] == 8'h10
    && !pc_vector_o[0] && pc_vector_o[3:0] != 4'h0)
    else $error("vector off page");
  chk_vec_bank: assert property (pc_load_o |->
    pc_vector_o[PC_W-1:12] == stack_pc_o[PC_W-1:12])
    else $error("vector in wrong bank");
  chk_halt_enter: assert property (halt_exec_i && !irq_o |=>
    halted_o)
    else $error("halt not entered");
  chk_halt_wake: assert property (halted_o && irq_o |=> !halted_o)
    else $error("no wake on request");
  chk_busy_push: assert property (stack_push_o |-> serv_busy_o)
    else $error("push outside service");
  chk_busy_end: assert property (pc_load_o |-> !serv_busy_o)
    else $error("service still busy at vector load");
endmodule

bind cihc_irq_halt cihc_checker #(.PC_W(PC_W)) chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .instr_end_i(instr_end_i), .halt_exec_i(halt_exec_i),
  .pc_next_i(pc_next_i), .irq_o(irq_o), .ie_o(ie_o), .halted_o(halted_o),
  .serv_busy_o(serv_busy_o),
  .stack_push_o(stack_push_o), .stack_pc_o(stack_pc_o),
  .pc_load_o(pc_load_o), .pc_vector_o(pc_vector_o));

// ==== bench/cihc_cpu_model.sv ====
// CPU stand-in: instruction-end pulses and the next PC.
// Assumes the controller clock and reset; slow_i stretches instructions.
`timescale 1ns/1ps
module cihc_cpu_model (
  input wire clk_i,
  input wire rst_i,
  input wire slow_i,
  output reg instr_end_o,
  output reg [12:0] pc_next_o
);
  reg [2:0] cnt_q;
  wire [2:0] lim = slow_i ? 3'h6 : 3'h1;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
      instr_end_o <= 1'b0;
      pc_next_o <= 13'h1ABC;
    end else begin
      // Bank bit set so a fixed-bank vector would show
      cnt_q <= (cnt_q >= lim) ? 3'h0 : cnt_q + 3'h1;
      instr_end_o <= (cnt_q >= lim);
      if (instr_end_o) begin
        pc_next_o <= pc_next_o + 13'h1;
      end
    end
  end
endmodule

// ==== bench/cihc_irq_halt_tb_top.sv ====
// Register, event, service and halt sequences for the controller.
// Assumes a word-indexed Avalon slave with one wait state.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
  end end
module cihc_irq_halt_tb_top;
  logic clk_i, rst_i, rd, wr, wreq, ptm, serr, srx, stx, ie_s, ie_c, hlt;
  logic slow, iend, irq, ie, halted, push, load, wdt, busy;
  logic [7:0] adr;
  logic [31:0] wd, rdata, r;
  logic [3:0] khi, klo, ct;
  logic [12:0] pcn, vec;
  int n_errors = 0, check_count = 0;
  logic [7:0] ra [13] = '{8'h90, 8'h92, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4,
    8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'h00};
  logic [3:0] rv [13] = '{1: 4'hF, default: 4'h0};
  logic [7:0] wa [8] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'h90, 8'h94,
    8'hF8};
  logic [3:0] wv [8] = '{4'h1, 4'h7, 4'h1, 4'h1, 4'hF, 4'hF, 4'hF, 4'h0};
  logic [7:0] fa [7] = '{8'hF8, 8'hF9, 8'hF9, 8'hF9, 8'hFA, 8'hFB, 8'hFC};
  logic [3:0] fb [7] = '{4'h1, 4'h4, 4'h1, 4'h2, 4'h1, 4'h1, 4'h1};
  cihc_irq_halt #(.WDT_CYC(50)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .ptm_zero_i(ptm), .sif_err_i(serr),
    .sif_rx_i(srx), .sif_tx_i(stx), .key_hi_i(khi), .key_lo_i(klo),
    .ct_tap_i(ct), .irq_en_set_i(ie_s), .irq_en_clr_i(ie_c),
    .instr_end_i(iend),
    .halt_exec_i(hlt), .pc_next_i(pcn), .irq_o(irq), .ie_o(ie),
    .halted_o(halted), .serv_busy_o(busy), .stack_push_o(push),
    .stack_pc_o(), .pc_load_o(load), .pc_vector_o(vec),
    .wdt_restart_o(wdt));
  cihc_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .instr_end_o(iend), .pc_next_o(pcn));
  always #5 clk_i = ~clk_i;
  task tally_and_finish;
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic acc(input bit w, input [7:0] a, input [3:0] d);
    int n = 0;
    @(posedge clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {28'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task rchk(input [7:0] a, input [3:0] e);
    acc(1'b0, a, 4'h0);
    `CHK(r, {28'h0, e})
  endtask
  // Waits on the vector load (0) or the watchdog restart (1)
  task automatic wait_on(input int s);
    int n = 0;
    while (n < 100 && !(s == 0 ? load === 1'b1 : wdt === 1'b1)) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task ctl(input [2:0] v);
    @(posedge clk_i);
    {hlt, ie_c, ie_s} <= v;
    @(posedge clk_i);
    {hlt, ie_c, ie_s} <= 3'h0;
  endtask
  task fire(input int k);
    @(posedge clk_i);
    case (k)
      0: ptm <= 1'b1;
      1: serr <= 1'b1;
      2: srx <= 1'b1;
      3: stx <= 1'b1;
      4: khi[0] <= 1'b0;
      5: klo[0] <= 1'b0;
      6: ct[0] <= 1'b1;
      7: ct <= 4'hE;
      default: {ptm, stx} <= 2'b11;
    endcase
    @(posedge clk_i);
    {ptm, serr, srx, stx} <= 4'h0;
    {khi, klo, ct} <= 12'hFF0;
  endtask
  initial begin
    {clk_i, rst_i, rd, wr, adr, wd} = {2'b01, 42'h0};
    {ptm, serr, srx, stx, ie_s, ie_c, hlt, slow} = 8'h0;
    {khi, klo, ct} = 12'hFF0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    ctl(3'b001);
    fire(7);
    fire(0);
    @(posedge clk_i);
    `CHK(irq, 1'b0)
    rchk(8'hFC, 4'hE);
    rchk(8'hF8, 4'h1);
    rchk(8'hF8, 4'h0);
    ctl(3'b010); // Masks are written here while disabled
    foreach (wa[i]) acc(1'b1, wa[i], 4'hF);
    foreach (wa[i]) rchk(wa[i], wv[i]);
    for (int k = 0; k < 7; k++) begin
      slow <= k[0];
      fire(k);
      // Tap flags land one edge after the pulse and key flags
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b0)
      ctl(3'b001);
      wait_on(0);
      `CHK(vec[3:0], 4'(2 * k + 2))
      `CHK(ie, 1'b0)
      rchk(fa[k], fb[k]); // Read while disabled
    end
    acc(1'b1, 8'h92, 4'h0);
    fire(5);
    rchk(8'hFB, 4'h1); // Compare 0 takes the rising edge
    acc(1'b1, 8'h90, 4'h0);
    fire(5);
    rchk(8'hFB, 4'h0);
    fire(8);
    ctl(3'b001);
    wait_on(0);
    `CHK(vec[3:0], 4'h2)
    rchk(8'hF8, 4'h1);
    ctl(3'b001);
    wait_on(0);
    `CHK(vec[3:0], 4'h8)
    rchk(8'hF9, 4'h2);
    ctl(3'b100);
    @(posedge clk_i);
    `CHK(halted, 1'b1)
    wait_on(1);
    @(posedge clk_i);
    `CHK(halted, 1'b0)
    ctl(3'b100);
    ctl(3'b001);
    `CHK(halted, 1'b1)
    fire(6);
    wait_on(0);
    `CHK(vec[3:0], 4'hE)
    `CHK(halted, 1'b0)
    `CHK(busy, 1'b0)
    // Second reset with masks and the lower key compare away from reset values
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    tally_and_finish();
  end
endmodule
